/* File: rtl/feig_top.v */
/*
  Processor-side floating-point error signalling in compatibility mode,
  with the external request latch and ignore-error glue instantiated.
  Assumes all inputs are synchronous to mclk and instruction events are
  one-cycle pulses from the core's sequencer.
*/
// Summary of operation
// - Unmasked exception in compat mode drives error
// - Clearing exception deasserts error output
// - Ignore active: x87 instructions never block
// - No-wait with pending exception pulses error
// - No-wait instruction continues, never freezes
// - Each x87 instruction samples interrupts
// - Late interrupt taken at next boundary
// - Deferred exception reported at next instruction
// - After clear, no-wait never asserts error
// - Ignore active: exception disregarded, error stays asserted
// - Ignore inactive: freeze until interrupt
`timescale 1ns/10ps
`default_nettype none
`include "feig_map.vh"

module feig_top
(
  input wire mclk,
  input wire rst_n,
  input wire native_fault_mode_bit,
  input wire fp_exc_unmasked,
  input wire fp_exc_deferred,
  input wire fp_exc_clear,
  input wire insn_start,
  input wire insn_nowait,
  input wire insn_boundary,
  input wire host_interrupt_in,
  input wire io_access,
  input wire [`FEIG_PORT_W-1:0] io_addr,
  output reg fpu_error_out_n,
  output wire float_irq_request,
  output wire ignore_numeric_fault_in_n,
  output reg cpu_frozen_q,
  output reg irq_in_window_q,
  output reg irq_at_boundary_q,
  output reg native_fault_trap_q
);

  reg pend_q;
  reg pend_d;
  reg defer_q;
  reg defer_d;
  reg hold_q;
  reg hold_d;
  reg frozen_d;
  reg [`FEIG_CNT_W-1:0] brief_q;
  reg [`FEIG_CNT_W-1:0] brief_d;
  reg [`FEIG_CNT_W-1:0] win_q;
  reg [`FEIG_CNT_W-1:0] win_d;
  reg ack_q;
  reg port_hit_q;
  reg win_irq;
  wire compat;
  wire ign_act;
  wire port_hit;
  wire start_wait;
  wire start_nw;

  assign compat = ~native_fault_mode_bit;
  assign ign_act = ~ignore_numeric_fault_in_n;
  assign start_wait = insn_start & ~insn_nowait;
  assign start_nw = insn_start & insn_nowait;
  // Full 16-bit match of the acknowledge port.
  assign port_hit = io_access & (io_addr == `FEIG_ACK_PORT);

  // True while a down-counter still has cycles to run. It serves both the
  // sampling window and the no-wait pulse counters.
  function cnt_busy;
    input [`FEIG_CNT_W-1:0] cnt;
    begin
      cnt_busy = (cnt != `FEIG_CNT_ZERO);
    end
  endfunction

  // Next-state logic of the exception, freeze and counter state.
  always @*
  begin
    pend_d = pend_q;
    defer_d = defer_q;
    hold_d = hold_q;
    frozen_d = cpu_frozen_q;
    brief_d = brief_q;
    win_d = win_q;
    // An interrupt is taken while frozen or while the sampling window is open.
    win_irq = host_interrupt_in & (cpu_frozen_q | cnt_busy(win_q));
    if (cnt_busy(win_q))
    begin
      win_d = win_q - `FEIG_CNT_ONE;
    end
    if (cnt_busy(brief_q))
    begin
      brief_d = brief_q - `FEIG_CNT_ONE;
    end
    // no later assert
    // Clearing the exception drops all pending state and ends a freeze.
    if (fp_exc_clear)
    begin
      pend_d = 1'b0;
      defer_d = 1'b0;
      hold_d = 1'b0;
      brief_d = `FEIG_CNT_ZERO;
      frozen_d = 1'b0;
    end
    // Every instruction, no-wait ones included, opens the sampling window.
    // open window
    if (insn_start)
    begin
      win_d = `FEIG_WINDOW_CYC;
    end
    if (win_irq)
    begin
      frozen_d = 1'b0;
    end
    // A new exception wins over a clear in the same cycle.
    if (fp_exc_unmasked)
    begin
      pend_d = 1'b1;
      defer_d = fp_exc_deferred;
      if (compat && !ign_act && !fp_exc_deferred)
      begin
        hold_d = 1'b1;
      end
    end
    else if (pend_q && compat && !ign_act && !fp_exc_clear)
    begin
      if (start_wait)
      begin
        hold_d = 1'b1;
        defer_d = 1'b0;
        frozen_d = 1'b1;
      end
      else if (start_nw && !hold_q)
      begin
        // The deferred mark stays set, so the pulse never turns into a held
        // assertion; only a later wait instruction holds and freezes.
        brief_d = `FEIG_NOWAIT_PULSE_CYC;
      end
      else if (!defer_q && !hold_q && !cnt_busy(brief_q))
      begin
        // An immediate exception left pending while ignore was active.
        hold_d = 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q <= 1'b0;
      defer_q <= 1'b0;
      hold_q <= 1'b0;
      brief_q <= `FEIG_CNT_ZERO;
      win_q <= `FEIG_CNT_ZERO;
      cpu_frozen_q <= 1'b0;
      fpu_error_out_n <= `FEIG_PIN_IDLE;
      irq_in_window_q <= 1'b0;
      irq_at_boundary_q <= 1'b0;
      native_fault_trap_q <= 1'b0;
      ack_q <= 1'b0;
      port_hit_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      defer_q <= defer_d;
      hold_q <= hold_d;
      brief_q <= brief_d;
      win_q <= win_d;
      cpu_frozen_q <= frozen_d;
      // The error pin follows the next state, so it moves at the causing edge.
      fpu_error_out_n <= ~(hold_d | cnt_busy(brief_d));
      irq_in_window_q <= win_irq;
      irq_at_boundary_q <= host_interrupt_in & insn_boundary & ~win_irq;
      // Native mode handles the fault inside the core; this pulse marks that trap.
      native_fault_trap_q <= native_fault_mode_bit & pend_q & start_wait;
      // A held I/O cycle acknowledges once, on its first sampled cycle.
      // one-cycle pulse
      port_hit_q <= port_hit;
      ack_q <= port_hit & ~port_hit_q;
    end
  end

  // The request and ignore-error flip-flops sit in their own module, which keeps
  // the asynchronous clear of the ignore-error flip-flop apart from the core.
  // exit releases ignore
  feig_latch u_latch
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .fpu_error_out_n(fpu_error_out_n),
    .ack_pulse(ack_q),
    .float_irq_request(float_irq_request),
    .ignore_numeric_fault_in_n(ignore_numeric_fault_in_n)
  );

endmodule // feig_top

`default_nettype wire

/* File: rtl/feig_map.vh */
/*
  Constants of the floating-point error and interrupt glue: the I/O port
  that acknowledges the error request, and the timing counts in cycles.
  Assumes a single 100 MHz clock (10 ns period).
*/
`ifndef FEIG_MAP_VH
`define FEIG_MAP_VH

// I/O port whose access clears the request and raises ignore-error.
`define FEIG_ACK_PORT 16'h00F0
`define FEIG_PORT_W 16

// Reset values of the active-low pins (inactive) and of the request.
`define FEIG_PIN_IDLE 1'h1
`define FEIG_REQ_IDLE 1'h0

// Width of the cycle counters.
`define FEIG_CNT_W 3
// Length of the brief error pulse raised by a no-wait instruction.
`define FEIG_NOWAIT_PULSE_CYC 3'h2
// Length of the interrupt sampling window opened by an x87 instruction.
`define FEIG_WINDOW_CYC 3'h4
`define FEIG_CNT_ZERO 3'h0
`define FEIG_CNT_ONE 3'h1

`endif

/* File: rtl/feig_latch.v */
/*
  Three-flip-flop glue between the error output and the ignore-error input.
  Assumes the acknowledge pulse is one clock wide and synchronous to mclk,
  and that the error output is a registered, glitch-free level.
*/
`timescale 1ns/10ps
`default_nettype none
`include "feig_map.vh"

module feig_latch
(
  input wire mclk,
  input wire rst_n,
  input wire fpu_error_out_n,
  input wire ack_pulse,
  output reg float_irq_request,
  output reg ignore_numeric_fault_in_n
);

  wire ign_clr_n;
  wire err_fall;
  reg err_prev_q;

  assign ign_clr_n = rst_n & ~fpu_error_out_n;

  // error assertion edge
  // The request is set on the assertion edge only, so an acknowledge while the
  // error output is still held active really clears it.
  assign err_fall = err_prev_q & ~fpu_error_out_n;

  // The last error level resets to the idle level, so no false edge follows reset.
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_prev_q <= `FEIG_PIN_IDLE;
    end
    else
    begin
      err_prev_q <= fpu_error_out_n;
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      float_irq_request <= `FEIG_REQ_IDLE;
    end
    else if (err_fall)
    begin
      // A new assertion wins over an acknowledge in the same cycle.
      float_irq_request <= 1'b1;
    end
    else if (ack_pulse)
    begin
      float_irq_request <= 1'b0;
    end
  end

  always @(posedge mclk or negedge ign_clr_n)
  begin
    if (!ign_clr_n)
    begin
      ignore_numeric_fault_in_n <= `FEIG_PIN_IDLE;
    end
    else if (ack_pulse)
    begin
      ignore_numeric_fault_in_n <= 1'b0;
    end
  end

endmodule // feig_latch

`default_nettype wire

/* File: verif/feig_pic_model.sv */
/* Interrupt controller stand-in that delays the request. Assumes mclk. */
`timescale 1ns/10ps
`default_nettype none
module feig_pic_model
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic float_irq_request,
  input wire logic [2:0] dly,
  output logic host_interrupt_in
);
  logic [7:0] req_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      req_q <= 8'h00;
    else
      req_q <= {req_q[6:0], float_irq_request};
  assign host_interrupt_in = req_q[dly];
endmodule // feig_pic_model
`default_nettype wire

/* File: verif/feig_chk_assertions.sv */
/* Checker on feig_top ports. Assumes it is bound into feig_top. */
`timescale 1ns/10ps
`default_nettype none
`include "feig_map.vh"
module feig_chk
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic native_fault_mode_bit,
  input wire logic fp_exc_unmasked,
  input wire logic fp_exc_deferred,
  input wire logic fp_exc_clear,
  input wire logic insn_start,
  input wire logic insn_nowait,
  input wire logic host_interrupt_in,
  input wire logic io_access,
  input wire logic [`FEIG_PORT_W-1:0] io_addr,
  input wire logic fpu_error_out_n,
  input wire logic float_irq_request,
  input wire logic ignore_numeric_fault_in_n,
  input wire logic cpu_frozen_q,
  input wire logic irq_in_window_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ack;
    $rose(io_access) && io_addr == `FEIG_ACK_PORT && !fpu_error_out_n
      ##1 !fpu_error_out_n [*3];
  endsequence
  sequence s_nw;
    insn_start && insn_nowait && fpu_error_out_n && ignore_numeric_fault_in_n
      ##1 !fpu_error_out_n;
  endsequence
  property p_imm;
    fp_exc_unmasked && !fp_exc_deferred && !native_fault_mode_bit
      && ignore_numeric_fault_in_n |=> !fpu_error_out_n;
  endproperty
  property p_lat; $fell(fpu_error_out_n) |=> float_irq_request; endproperty
  property p_ack; s_ack |-> !float_irq_request && !ignore_numeric_fault_in_n; endproperty
  property p_asy; fpu_error_out_n |-> ignore_numeric_fault_in_n; endproperty
  property p_clr; fp_exc_clear && !fp_exc_unmasked |=> fpu_error_out_n; endproperty
  property p_nw; s_nw |=> !fpu_error_out_n && !cpu_frozen_q ##1 fpu_error_out_n; endproperty
  property p_frz; cpu_frozen_q && host_interrupt_in |=> !cpu_frozen_q && irq_in_window_q;
  endproperty
  property p_nat; native_fault_mode_bit && fpu_error_out_n |=> fpu_error_out_n; endproperty
  a_imm: assert property (p_imm) else $error("error not raised");
  a_lat: assert property (p_lat) else $error("request not set");
  a_ack: assert property (p_ack) else $error("ack ignored");
  a_asy: assert property (p_asy) else $error("ignore while idle");
  a_clr: assert property (p_clr) else $error("error not released");
  a_nw: assert property (p_nw) else $error("bad no-wait pulse");
  a_frz: assert property (p_frz) else $error("freeze not left");
  a_nat: assert property (p_nat) else $error("error in native mode");
endmodule // feig_chk
bind feig_top feig_chk i_chk (.*);
`default_nettype wire

/* File: verif/feig_top_tb_top.sv */
/* Bench for feig_top with the interrupt stand-in. Assumes rtl headers on path. */
`timescale 1ns/10ps
`default_nettype none
`include "feig_map.vh"
`define CHK(n, e, v) num_checks++; if ((v) !== (e)) begin \
  $display("wrong value %s exp %0h got %0h", n, e, v); err_count++; end
module feig_top_tb_top;
  logic mclk, rst_n, native_fault_mode_bit, fp_exc_unmasked, fp_exc_deferred;
  logic fp_exc_clear, insn_start, insn_nowait, insn_boundary, host_interrupt_in;
  logic io_access, fpu_error_out_n, float_irq_request, ignore_numeric_fault_in_n;
  logic cpu_frozen_q, irq_in_window_q, irq_at_boundary_q, native_fault_trap_q;
  logic [`FEIG_PORT_W-1:0] io_addr;
  logic [2:0] dly;
  int err_count, num_checks, cyc, n_win, n_bnd, n_frz, n_lo;
  feig_top i_dut (.*);
  feig_pic_model i_pic (.*);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    n_win += irq_in_window_q;
    n_bnd += irq_at_boundary_q;
    n_frz += cpu_frozen_q;
    n_lo += !fpu_error_out_n;
    if (cyc == 1000)
    begin
      err_count++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task ack();
    io_access = 1'b1;
    step(1);
    io_access = 1'b0;
    step(4);
  endtask
  task exc(input logic d);
    fp_exc_unmasked = 1'b1;
    fp_exc_deferred = d;
    step(1);
    fp_exc_unmasked = 1'b0;
    step(3);
  endtask
  task clr();
    fp_exc_clear = 1'b1;
    step(1);
    fp_exc_clear = 1'b0;
    step(8);
  endtask
  task ins(input logic nw);
    insn_start = 1'b1;
    insn_nowait = nw;
    step(1);
    insn_start = 1'b0;
  endtask
  task t_handler();
    exc(1'b0);
    `CHK("err", 1'b0, fpu_error_out_n) // raise
    `CHK("req", 1'b1, float_irq_request) // latch
    io_addr = 16'h00F1;
    ack();
    `CHK("req", 1'b1, float_irq_request) // other port
    io_addr = `FEIG_ACK_PORT;
    ack();
    `CHK("req", 1'b0, float_irq_request) // cleared
    `CHK("ign", 1'b0, ignore_numeric_fault_in_n) // active
    clr();
    `CHK("err", 1'b1, fpu_error_out_n) // released
    `CHK("ign", 1'b1, ignore_numeric_fault_in_n) // released
  endtask
  task t_order();
    exc(1'b0);
    clr();
    ack();
    `CHK("ign", 1'b1, ignore_numeric_fault_in_n) // stays off
    `CHK("req", 1'b0, float_irq_request) // cleared
  endtask
  task t_defer();
    dly = 3'h1;
    n_win = 0;
    n_frz = 0;
    exc(1'b1);
    `CHK("err", 1'b1, fpu_error_out_n) // held back
    ins(1'b0);
    step(8);
    `CHK("frz", 1'b1, n_frz > 0) // freeze
    `CHK("win", 1'b1, n_win > 0) // serviced
    ack();
    clr();
  endtask
  task t_nowait();
    dly = 3'h7;
    n_frz = 0;
    n_bnd = 0;
    n_lo = 0;
    exc(1'b1);
    ins(1'b1);
    step(14);
    insn_boundary = 1'b1;
    step(1);
    insn_boundary = 1'b0;
    step(2);
    `CHK("frz", 0, n_frz) // no freeze
    `CHK("bnd", 1'b1, n_bnd > 0) // boundary
    `CHK("low", `FEIG_NOWAIT_PULSE_CYC, n_lo) // brief
    `CHK("req", 1'b1, float_irq_request) // latched
    ack();
    `CHK("ign", 1'b1, ignore_numeric_fault_in_n) // stays off
    clr();
    n_lo = 0;
    ins(1'b1);
    step(4);
    native_fault_mode_bit = 1'b1;
    exc(1'b0);
    ins(1'b0);
    `CHK("trap", 1'b1, native_fault_trap_q) // native trap
    `CHK("low", 0, n_lo) // quiet
    clr();
    native_fault_mode_bit = 1'b0;
  endtask
  initial
  begin
    {rst_n, native_fault_mode_bit, fp_exc_unmasked, fp_exc_deferred} = '0;
    {fp_exc_clear, insn_start, insn_nowait, insn_boundary, io_access} = '0;
    io_addr = `FEIG_ACK_PORT;
    dly = 3'h1;
    step(10);
    rst_n = 1'b1;
    step(2);
    t_handler();
    t_order();
    t_defer();
    t_nowait();
    summarize();
  end
endmodule // feig_top_tb_top
`default_nettype wire
